// ===== verilog/onboard_dma_interrupt_priority.sv
// three-channel dma engine with arbitration, plus interrupt daisy chain
// assumes synchronous inputs, one-cycle register strobes, fixed-time memory
`include "onboard_dma_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module onboard_dma_interrupt_priority #(
	parameter int CHANNELS = 3,
	parameter int PIC_INPUTS = 8
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire onboard_dma_pkg::dma_req_s dma_req,
	output logic hold_to_cpu,
	output logic bus_isolate,
	output onboard_dma_pkg::mem_cycle_s mem_cycle,
	input wire logic [15:0] mem_rdata,
	input wire logic addr_translated,
	output logic mem_offboard,
	output logic [CHANNELS-1:0] dma_done,
	input wire logic [PIC_INPUTS-1:0] pic_req,
	input wire onboard_dma_pkg::sp_irq_s sp_req,
	output logic cpu_int0,
	output logic cpu_int1,
	output logic chain_enable_out,
	input wire logic inta,
	input wire logic inta_second,
	output logic [7:0] ack_data,
	output logic ack_valid
);

	// used for both the fixed chain and the controller, which may rotate
	// first set bit of v searching upward from start, wrapping; the bit nearest start is found
	function automatic logic [3:0] first_set(input logic [7:0] v, input logic [2:0] start);
		logic [3:0] r;
		logic [2:0] j;
		r = 4'h0;
		for (int i = 7; i >= 0; i--) begin
			j = start + 3'(i);
			if (v[j]) begin
				r = {1'b1, j};
			end
		end
		return r;
	endfunction : first_set

	// per-channel working values and the copies that a reload restores;
	// software writes both, the engine steps only the working set
	onboard_dma_pkg::dma_ctrl_s ctrl [CHANNELS];
	logic [19:0] src [CHANNELS];
	logic [19:0] dst [CHANNELS];
	logic [15:0] cnt [CHANNELS];
	logic [19:0] src_base [CHANNELS];
	logic [19:0] dst_base [CHANNELS];
	logic [15:0] cnt_base [CHANNELS];

	// global settings written by software, plus the rotation pointer that acknowledges set
	logic floppy_low;
	logic [7:0] pic_mask;
	logic [7:0] pic_vbase;
	logic pic_rotate;
	logic [7:0] sp_vbase;
	logic [2:0] rot_ptr;

	// engine state, current channel and phase timing
	onboard_dma_pkg::dma_state_e state;
	logic [1:0] cur;
	logic [7:0] phase_cnt;
	logic [15:0] data_latch;

	// arbitration and decode helpers
	logic unit_done;
	logic block_end;
	logic [1:0] next_ch;
	logic ch1_ready;
	logic ch2_ready;
	logic ch0_ready;
	logic ch_sel;
	logic [1:0] field;
	logic [1:0] ch_idx;
	logic [4:0] step;

	// interrupt picks: bit 3 flags a winner, bits 2:0 its index
	logic [3:0] sp_pick;
	logic [3:0] pic_pick;
	logic [7:0] pic_pend;

	// register decode: channel block versus globals
	assign ch_idx = reg_addr[5:4];
	assign field = reg_addr[3:2];
	assign ch_sel = (reg_addr[7:6] == 2'b00) && (ch_idx != 2'd3) && (reg_addr[1:0] == 2'b00);

	// channel readiness; free-running channels move memory without a request
	assign ch0_ready = ctrl[0].run && ctrl[0].pass && dma_req.hold;
	assign ch1_ready = ctrl[1].run && (ctrl[1].free || dma_req.floppy);
	assign ch2_ready = ctrl[2].run && (ctrl[2].free || dma_req.serial);

	// floppy versus serial order is software chosen, bus hold beats both
	always_comb begin
		next_ch = 2'd0;
		if (ch1_ready && ch2_ready) begin
			next_ch = floppy_low ? 2'd2 : 2'd1;
		end else if (ch1_ready) begin
			next_ch = 2'd1;
		end else if (ch2_ready) begin
			next_ch = 2'd2;
		end
	end

	assign unit_done = (state == onboard_dma_pkg::ST_WRITE) && (phase_cnt == 8'd0);
	assign block_end = unit_done && (cnt[cur] == 16'd1);
	assign step = ctrl[cur].word ? 5'd2 : 5'd1;

	// one unit is a read phase then a write phase of equal length; the
	// memory is assumed to answer within the read phase, so there is no wait
	// input and a slow target would need a longer phase count
	// transfer engine; re-arbitrates after every unit so a hold can get in
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state <= onboard_dma_pkg::ST_IDLE;
			cur <= 2'd0;
			phase_cnt <= 8'h00;
			data_latch <= 16'h0000;
			mem_cycle <= '0;
		end else begin
			unique case (state)
				onboard_dma_pkg::ST_IDLE: begin
					mem_cycle.rd <= 1'b0;
					mem_cycle.wr <= 1'b0;
					if (ch0_ready) begin
						state <= onboard_dma_pkg::ST_PASS;
						cur <= 2'd0;
					end else if (next_ch != 2'd0) begin
						state <= onboard_dma_pkg::ST_READ;
						cur <= next_ch;
						phase_cnt <= 8'(`PHASE_CYCLES - 1);
						mem_cycle.addr <= src[next_ch];
						mem_cycle.io <= ctrl[next_ch].src_io;
						mem_cycle.word <= ctrl[next_ch].word;
						mem_cycle.rd <= 1'b1;
					end
				end
				onboard_dma_pkg::ST_PASS: begin
					// stays isolated until the off-board master lets go or software clears run
					if (!dma_req.hold || !ctrl[0].run) begin
						state <= onboard_dma_pkg::ST_IDLE;
					end
				end
				onboard_dma_pkg::ST_READ: begin
					if (!ctrl[cur].run) begin
						state <= onboard_dma_pkg::ST_IDLE;
						mem_cycle.rd <= 1'b0;
					end else if (phase_cnt == 8'd0) begin
						state <= onboard_dma_pkg::ST_WRITE;
						phase_cnt <= 8'(`PHASE_CYCLES - 1);
						data_latch <= mem_rdata;
						mem_cycle.wdata <= mem_rdata;
						mem_cycle.addr <= dst[cur];
						mem_cycle.io <= ctrl[cur].dst_io;
						mem_cycle.rd <= 1'b0;
						mem_cycle.wr <= 1'b1;
					end else begin
						phase_cnt <= phase_cnt - 8'd1;
					end
				end
				onboard_dma_pkg::ST_WRITE: begin
					if (!ctrl[cur].run || phase_cnt == 8'd0) begin
						state <= onboard_dma_pkg::ST_IDLE;
						mem_cycle.wr <= 1'b0;
					end else begin
						phase_cnt <= phase_cnt - 8'd1;
					end
				end
			endcase
		end
	end


	// hold and isolation come straight from the state register, so they
	// rise one cycle after the request, or one cycle after a running unit ends, and drop one cycle after it goes
	// channel pass-through and bus hold toward the processor
	assign hold_to_cpu = (state == onboard_dma_pkg::ST_PASS);
	assign bus_isolate = (state == onboard_dma_pkg::ST_PASS);
	// translated memory addresses are steered off board; i/o never is
	assign mem_offboard = addr_translated && (mem_cycle.rd || mem_cycle.wr) && !mem_cycle.io;

	// pulse lasts one cycle; a level would need a clear path from software
	// end-of-block pulse only where enabled
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			dma_done <= '0;
		end else begin
			for (int c = 0; c < CHANNELS; c++) begin
				dma_done[c] <= block_end && (cur == 2'(c)) && ctrl[c].irq_en;
			end
		end
	end

	// the i/o side keeps its port address so a peripheral is hit repeatedly;
	// a count of zero is not special and runs through the full 16-bit range
	// addresses and counts: software loads, engine steps and reloads
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			for (int c = 0; c < CHANNELS; c++) begin
				src[c] <= 20'h00000;
				dst[c] <= 20'h00000;
				cnt[c] <= 16'h0000;
				src_base[c] <= 20'h00000;
				dst_base[c] <= 20'h00000;
				cnt_base[c] <= 16'h0000;
			end
		end else begin
			if (unit_done) begin
				if (block_end && ctrl[cur].reload) begin
					src[cur] <= src_base[cur];
					dst[cur] <= dst_base[cur];
					cnt[cur] <= cnt_base[cur];
				end else begin
					// i/o side keeps its port address
					src[cur] <= ctrl[cur].src_io ? src[cur] : src[cur] + 20'(step);
					dst[cur] <= ctrl[cur].dst_io ? dst[cur] : dst[cur] + 20'(step);
					cnt[cur] <= cnt[cur] - 16'd1;
				end
			end
			// a software write lands after the engine step, so it wins
			if (reg_wr && ch_sel) begin
				unique case (field)
					`CH_SRC: begin
						src[ch_idx] <= reg_wdata[19:0];
						src_base[ch_idx] <= reg_wdata[19:0];
					end
					`CH_DST: begin
						dst[ch_idx] <= reg_wdata[19:0];
						dst_base[ch_idx] <= reg_wdata[19:0];
					end
					`CH_CNT: begin
						cnt[ch_idx] <= reg_wdata[15:0];
						cnt_base[ch_idx] <= reg_wdata[15:0];
					end
					`CH_CTRL: begin
					end
				endcase
			end
		end
	end

	// software wins over the block-end clear so a rewrite of run is never lost
	// channel control; run bit self-clears at block end unless reloading
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			for (int c = 0; c < CHANNELS; c++) begin
				ctrl[c] <= `CTRL_RESET;
			end
		end else begin
			if (block_end && !ctrl[cur].reload) begin
				ctrl[cur].run <= 1'b0;
			end
			if (reg_wr && ch_sel && field == `CH_CTRL) begin
				ctrl[ch_idx] <= reg_wdata[7:0];
			end
		end
	end

	// priority, mask, vector bases and rotation; a running unit is not disturbed
	// global settings
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			floppy_low <= `PRIO_RESET;
			pic_mask <= `MASK_RESET;
			pic_vbase <= `VBASE_RESET;
			pic_rotate <= 1'b0;
			sp_vbase <= `VBASE_RESET;
		end else if (reg_wr) begin
			unique case (reg_addr)
				`REG_PRIO: floppy_low <= reg_wdata[0];
				`REG_PIC_MASK: pic_mask <= reg_wdata[7:0];
				`REG_PIC_VBASE: pic_vbase <= reg_wdata[7:0];
				`REG_PIC_MODE: pic_rotate <= reg_wdata[0];
				`REG_SP_VBASE: sp_vbase <= reg_wdata[7:0];
				default: begin
				end
			endcase
		end
	end


	// a read strobe with no mapped address still refreshes the data to zero
	// read data one cycle after the strobe; unmapped reads zero
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_rd) begin
			reg_rdata <= 32'h00000000;
			if (ch_sel) begin
				unique case (field)
					`CH_SRC: reg_rdata <= {12'h000, src[ch_idx]};
					`CH_DST: reg_rdata <= {12'h000, dst[ch_idx]};
					`CH_CNT: reg_rdata <= {16'h0000, cnt[ch_idx]};
					`CH_CTRL: reg_rdata <= {24'h000000, ctrl[ch_idx]};
				endcase
			end else begin
				unique case (reg_addr)
					`REG_PRIO: reg_rdata <= {31'h00000000, floppy_low};
					`REG_PIC_MASK: reg_rdata <= {24'h000000, pic_mask};
					`REG_PIC_VBASE: reg_rdata <= {24'h000000, pic_vbase};
					`REG_PIC_MODE: reg_rdata <= {31'h00000000, pic_rotate};
					`REG_SP_VBASE: reg_rdata <= {24'h000000, sp_vbase};
					`REG_STATUS: reg_rdata <= {16'h0000, pic_pend, 1'b0, rot_ptr, 2'(state), cur};
					default: reg_rdata <= 32'h00000000;
				endcase
			end
		end
	end


	// the chain is purely combinational so a request that changes during an
	// acknowledge is seen at once; the winner is latched into the vector only
	// interrupt chain: serial first (A then B, rx tx ext), then parallel
	assign sp_pick = first_set(sp_req, 3'd0);
	// serial enable in is held high; its enable out feeds the parallel one
	assign chain_enable_out = !(|sp_req[5:0]);
	assign pic_pend = pic_req & ~pic_mask;
	assign pic_pick = first_set(pic_pend, pic_rotate ? rot_ptr + 3'd1 : 3'd0);
	// serial/parallel on input zero outrank the controller on input one
	assign cpu_int0 = |sp_req;
	assign cpu_int1 = pic_pick[3];


	// the two acknowledge cycles are told apart by inta_second; a cycle with no
	// pending source returns no valid flag and leaves the last vector in place
	// acknowledge cycles: zero gives chain vector, one the controller's
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ack_data <= 8'h00;
			ack_valid <= 1'b0;
			rot_ptr <= 3'd7;
		end else begin
			ack_valid <= 1'b0;
			if (inta && !inta_second && sp_pick[3]) begin
				ack_data <= sp_vbase + {5'h00, sp_pick[2:0]};
				ack_valid <= 1'b1;
			end else if (inta && inta_second && pic_pick[3]) begin
				ack_data <= pic_vbase + {5'h00, pic_pick[2:0]};
				ack_valid <= 1'b1;
				// serviced level becomes lowest when rotating
				rot_ptr <= pic_pick[2:0];
			end
		end
	end

endmodule : onboard_dma_interrupt_priority

`default_nettype wire

// ===== verilog/onboard_dma_cfg.svh
// constants for the on-board dma and interrupt priority block
// assumes a 100 MHz design clock and a byte-addressed register port
`ifndef ONBOARD_DMA_CFG_SVH
`define ONBOARD_DMA_CFG_SVH

// channel register offsets, channel n at n * stride
`define CH_STRIDE 8'h10
`define CH_SRC 2'h0
`define CH_DST 2'h1
`define CH_CNT 2'h2
`define CH_CTRL 2'h3

// global register offsets
`define REG_PRIO 8'h30
`define REG_PIC_MASK 8'h34
`define REG_PIC_VBASE 8'h38
`define REG_PIC_MODE 8'h3c
`define REG_SP_VBASE 8'h40
`define REG_STATUS 8'h44

// control field positions
`define CTRL_RUN 0
`define CTRL_WORD 1
`define CTRL_SRC_IO 2
`define CTRL_DST_IO 3
`define CTRL_IRQ_EN 4
`define CTRL_RELOAD 5
`define CTRL_FREE 6
`define CTRL_PASS 7

// reset values
`define CTRL_RESET 8'h00
`define PRIO_RESET 1'b0
`define MASK_RESET 8'hff
`define VBASE_RESET 8'h00

// timing: one transfer unit takes 8 processor clocks of 125 ns
`define CPU_CLK_NS 125
`define UNIT_CPU_CLKS 8
`define UNIT_TIME_NS (`UNIT_CPU_CLKS * `CPU_CLK_NS)
`define SYS_CLK_NS 10
`define UNIT_CYCLES (`UNIT_TIME_NS / `SYS_CLK_NS)
`define PHASE_CYCLES (`UNIT_CYCLES / 2)

`endif

// ===== verilog/onboard_dma_pkg.sv
// types shared by the on-board dma and interrupt priority block
// assumes the cfg header is included by the design file
package onboard_dma_pkg;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_PASS,
		ST_READ,
		ST_WRITE
	} dma_state_e;

	// control byte of one channel, msb first
	typedef struct packed {
		logic pass;
		logic free;
		logic reload;
		logic irq_en;
		logic dst_io;
		logic src_io;
		logic word;
		logic run;
	} dma_ctrl_s;

	// dma request lines
	typedef struct packed {
		logic serial;
		logic floppy;
		logic hold;
	} dma_req_s;

	// one memory or i/o cycle driven by the engine
	typedef struct packed {
		logic [19:0] addr;
		logic [15:0] wdata;
		logic rd;
		logic wr;
		logic io;
		logic word;
	} mem_cycle_s;

	// serial and parallel interrupt sources, highest priority in bit 0
	typedef struct packed {
		logic par_b;
		logic par_a;
		logic ser_b_ext;
		logic ser_b_tx;
		logic ser_b_rx;
		logic ser_a_ext;
		logic ser_a_tx;
		logic ser_a_rx;
	} sp_irq_s;

endpackage : onboard_dma_pkg

// ===== testbench/dma_mem_model.sv
// memory and i/o space seen by the dma engine
// assumes the engine samples read data on its last read cycle
`timescale 1ns/1ps
`default_nettype none
module dma_mem_model (
	input wire logic clk,
	input wire onboard_dma_pkg::mem_cycle_s mem_cycle,
	output logic [15:0] mem_rdata
);
	// data tied to address; lines flip when no read runs, so stale data never looks valid
	always_ff @(posedge clk) begin
		mem_rdata <= mem_cycle.rd ? {~mem_cycle.addr[7:0], mem_cycle.addr[7:0]} : ~mem_rdata;
	end
endmodule : dma_mem_model
`default_nettype wire

// ===== testbench/onboard_dma_asserts.sv
// port assertions for the dma and interrupt priority block
// assumes a bind to the top module and one clock domain
`timescale 1ns/1ps
`default_nettype none
module onboard_dma_checker (
	input wire logic clk,
	input wire logic reset,
	input wire onboard_dma_pkg::dma_req_s dma_req,
	input wire logic hold_to_cpu,
	input wire logic bus_isolate,
	input wire onboard_dma_pkg::mem_cycle_s mem_cycle,
	input wire logic addr_translated,
	input wire logic mem_offboard,
	input wire onboard_dma_pkg::sp_irq_s sp_req,
	input wire logic cpu_int0,
	input wire logic chain_enable_out,
	input wire logic inta,
	input wire logic inta_second,
	input wire logic ack_valid
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	// a unit: 50 read cycles, then 50 write cycles
	read_phase_len_a: assert property ($rose(mem_cycle.rd) |-> ##49 mem_cycle.rd ##1 (!mem_cycle.rd && mem_cycle.wr))
		else $error("read phase length wrong");
	write_phase_len_a: assert property ($rose(mem_cycle.wr) |-> ##49 mem_cycle.wr ##1 !mem_cycle.wr)
		else $error("write phase length wrong");
	// isolation and hold
	isolate_follows_hold_a: assert property (bus_isolate == hold_to_cpu) else $error("isolate differs");
	hold_quiet_bus_a: assert property (hold_to_cpu |-> !(mem_cycle.rd || mem_cycle.wr)) else $error("cycle in hold");
	hold_cause_a: assert property ($rose(hold_to_cpu) |-> $past(dma_req.hold)) else $error("hold without request");
	offboard_route_a: assert property (mem_offboard == (addr_translated && (mem_cycle.rd || mem_cycle.wr) && !mem_cycle.io))
		else $error("offboard select wrong");
	// interrupt chain
	int_zero_or_a: assert property (cpu_int0 == (|sp_req)) else $error("int0 wrong");
	chain_enable_a: assert property (chain_enable_out == !(|sp_req[5:0])) else $error("chain enable wrong");
	ack_refused_a: assert property (inta && !inta_second && sp_req == 8'h00 |=> !ack_valid) else $error("ack unasked");
	ack_given_a: assert property (inta && !inta_second && sp_req != 8'h00 |=> ack_valid) else $error("ack missing");
	cover property ($rose(hold_to_cpu));
	cover property ($rose(mem_cycle.wr));
	cover property (ack_valid);
endmodule : onboard_dma_checker
bind onboard_dma_interrupt_priority onboard_dma_checker chk_i (.clk(clk), .reset(reset), .dma_req(dma_req),
	.hold_to_cpu(hold_to_cpu), .bus_isolate(bus_isolate), .mem_cycle(mem_cycle), .addr_translated(addr_translated),
	.mem_offboard(mem_offboard), .sp_req(sp_req), .cpu_int0(cpu_int0), .chain_enable_out(chain_enable_out),
	.inta(inta), .inta_second(inta_second), .ack_valid(ack_valid));
`default_nettype wire

// ===== testbench/tb_onboard_dma_interrupt_priority.sv
// self-checking bench for the dma and interrupt priority block
// assumes the package is compiled first and a 100 MHz clock
`timescale 1ns/1ps
`default_nettype none
module tb_onboard_dma_interrupt_priority;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic [31:0] reg_rdata;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	onboard_dma_pkg::dma_req_s dma_req = '0;
	onboard_dma_pkg::mem_cycle_s mem_cycle;
	onboard_dma_pkg::sp_irq_s sp_req = '0;
	logic [15:0] mem_rdata;
	logic [2:0] dma_done;
	logic [7:0] pic_req = 8'h00;
	logic [7:0] ack_data;
	logic hold_to_cpu, bus_isolate, mem_offboard, cpu_int0, cpu_int1, chain_enable_out, ack_valid;
	logic addr_translated = 1'b0;
	logic inta = 1'b0;
	logic inta_second = 1'b0;
	int failures = 0;
	int n_checks = 0;
	int cyc = 0;
	always #5 clk = ~clk;
	onboard_dma_interrupt_priority dut (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dma_req(dma_req), .hold_to_cpu(hold_to_cpu),
		.bus_isolate(bus_isolate), .mem_cycle(mem_cycle), .mem_rdata(mem_rdata), .addr_translated(addr_translated),
		.mem_offboard(mem_offboard), .dma_done(dma_done), .pic_req(pic_req), .sp_req(sp_req), .cpu_int0(cpu_int0),
		.cpu_int1(cpu_int1), .chain_enable_out(chain_enable_out), .inta(inta), .inta_second(inta_second),
		.ack_data(ack_data), .ack_valid(ack_valid));
	dma_mem_model mem (.clk(clk), .mem_cycle(mem_cycle), .mem_rdata(mem_rdata));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic give_verdict();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : give_verdict
	// register port: one-cycle strobes, read data in the following cycle, held until the next read strobe
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask : rd
	// acknowledge cycle; expected value is {valid, vector}, vector 0 when refused
	task automatic ack(input logic sec, input logic [8:0] exp);
		@(posedge clk);
		inta <= 1'b1;
		inta_second <= sec;
		@(posedge clk);
		inta <= 1'b0;
		#1;
		chk({ack_valid, ack_valid ? ack_data : 8'h00}, exp);
	endtask : ack
	function automatic logic sig(input int k);
		case (k)
			0: return mem_cycle.rd;
			1: return mem_cycle.wr;
			2: return dma_done[1];
			default: return hold_to_cpu;
		endcase
	endfunction : sig
	// bounded wait, sampled just after each edge so a one-cycle pulse is seen
	task automatic wait_sig(input int k, input logic v);
		int i;
		for (i = 0; i < 400 && sig(k) !== v; i++) @(posedge clk) #1;
		chk(sig(k), v);
	endtask : wait_sig
	// hang guard, well above the several hundred cycles the sequence needs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			give_verdict();
		end
	end
	initial begin
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		for (int n = 0; n < 3; n++) rd(8'(12 + 16 * n), 32'h0);
		rd(8'h34, 32'hff);
		rd(8'h50, 32'h0);
		rd(8'h11, 32'h0);
		// word memory to memory, two units, end-of-block pulse, translated target
		addr_translated <= 1'b1;
		wr(8'h10, 32'h100);
		wr(8'h14, 32'h200);
		wr(8'h18, 32'h2);
		wr(8'h1c, 32'h53);
		wait_sig(0, 1'b1);
		chk(mem_cycle.addr, 20'h00100);
		chk(mem_offboard, 1'b1);
		wait_sig(1, 1'b1);
		chk(mem_cycle.addr, 20'h00200);
		chk(mem_cycle.wdata, 16'hff00);
		wait_sig(0, 1'b0);
		wait_sig(0, 1'b1);
		chk(mem_cycle.addr, 20'h00102);
		wait_sig(2, 1'b1);
		rd(8'h1c, 32'h52);
		addr_translated <= 1'b0;
		// floppy against serial, both orders
		for (int p = 0; p < 2; p++) begin
			wr(8'h30, 32'(p));
			wr(8'h10, 32'h1000);
			wr(8'h18, 32'h1);
			wr(8'h1c, 32'h1);
			wr(8'h20, 32'h2000);
			wr(8'h28, 32'h1);
			wr(8'h2c, 32'h1);
			dma_req <= 3'b110;
			wait_sig(0, 1'b1);
			chk(mem_cycle.addr, p ? 20'h02000 : 20'h01000);
			repeat (210) @(posedge clk);
			dma_req <= 3'b000;
		end
		// bus hold raised together with floppy: hold goes first
		wr(8'h0c, 32'h81);
		wr(8'h10, 32'h3000);
		wr(8'h18, 32'h1);
		wr(8'h1c, 32'h1);
		dma_req <= 3'b011;
		wait_sig(3, 1'b1);
		chk(mem_cycle.rd, 1'b0);
		chk(bus_isolate, 1'b1);
		dma_req <= 3'b010;
		wait_sig(3, 1'b0);
		wait_sig(0, 1'b1);
		chk(mem_cycle.addr, 20'h03000);
		dma_req <= 3'b000;
		// controller vectors, rotating then fixed, masking
		wr(8'h34, 32'h0);
		wr(8'h38, 32'h40);
		wr(8'h3c, 32'h1);
		wr(8'h40, 32'h80);
		pic_req <= 8'h08;
		ack(1'b1, 9'h143);
		pic_req <= 8'h11;
		ack(1'b1, 9'h144);
		wr(8'h3c, 32'h0);
		ack(1'b1, 9'h140);
		wr(8'h34, 32'hff);
		#1;
		chk(cpu_int1, 1'b0);
		sp_req <= 8'h0a;
		ack(1'b0, 9'h181);
		chk(cpu_int0, 1'b1);
		chk(chain_enable_out, 1'b0);
		sp_req <= 8'h30;
		ack(1'b0, 9'h184);
		sp_req <= 8'hc0;
		ack(1'b0, 9'h186);
		chk(chain_enable_out, 1'b1);
		sp_req <= 8'h00;
		ack(1'b0, 9'h000);
		// reset in mid-transfer
		wr(8'h10, 32'h400);
		wr(8'h18, 32'h5);
		wr(8'h1c, 32'h41);
		wait_sig(0, 1'b1);
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		#1;
		chk(mem_cycle.rd, 1'b0);
		rd(8'h1c, 32'h0);
		give_verdict();
	end
endmodule : tb_onboard_dma_interrupt_priority
`default_nettype wire
